// >>> rtl/irq_defs.svh
/*
 * Register map, field positions, reset values and response codes of the
 * priority interrupt controller.
 * Assumes inclusion by every file that decodes registers.
 */
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH

// register indices; byte address is four times the index
`define IRQ_IDX_ENABLE 12'h0a8
`define IRQ_IDX_PRIO_HI 12'h0b7
`define IRQ_IDX_PRIO_LO 12'h0b8
`define IRQ_IDX_STATUS 12'h0c0
`define IRQ_IDX_MASK 12'h0c1
`define IRQ_IDX_BITOP 12'h0c2
`define IRQ_IDX_SERVICE 12'h0c3

`define IRQ_GATE_BIT 7
`define IRQ_NUM_SRC 7
`define IRQ_ENABLE_RST 8'h00
`define IRQ_PRIO_RST 7'h00
`define IRQ_STATUS_RST 7'h00
`define IRQ_MASK_RST 7'h00

// bit-access command fields
`define IRQ_BITOP_IDX_LSB 0
`define IRQ_BITOP_VAL_BIT 3
`define IRQ_BITOP_SEL_BIT 4

`define IRQ_RESP_OKAY 2'b00
`define IRQ_RESP_SLVERR 2'b10

`endif

// >>> rtl/irq_pkg.sv
/*
 * Types shared by the interrupt controller modules.
 * Assumes irq_defs.svh supplies the numeric constants.
 */
package irq_pkg;
   typedef logic [1:0] level_t;
   typedef logic [2:0] vector_t;
   typedef logic [6:0] srcvec_t;
   typedef logic [13:0] addr_t;
   typedef enum logic [2:0] {
      SRC_EXT0 = 3'b000,
      SRC_TMR0 = 3'b001,
      SRC_EXT1 = 3'b010,
      SRC_TMR1 = 3'b011,
      SRC_SERIAL = 3'b100,
      SRC_TMR2 = 3'b101,
      SRC_COUNTER_ARRAY = 3'b110
   } source_e;
endpackage

// >>> rtl/arb_if.sv
/*
 * Carrier between the controller's register side and its arbiter.
 * Assumes both ends share ref_clk.
 */
`timescale 1ns/1ns
interface arb_if;
   import irq_pkg::*;
   srcvec_t pending;
   logic [7:0] enable;
   srcvec_t prioLo;
   srcvec_t prioHi;
   logic [3:0] inService;
   logic ack;
   logic valid;
   vector_t vector;
   level_t level;
   modport ctl(output pending, enable, prioLo, prioHi, inService, ack,
      input valid, vector, level);
   modport arb(input pending, enable, prioLo, prioHi, inService, ack,
      output valid, vector, level);
endinterface

// >>> rtl/irq_arbiter.sv
/*
 * Picks the request to present to the core: level first, then poll order.
 * Assumes pending, registers and in-service levels from the same clock.
 */
`timescale 1ns/1ns
`include "irq_defs.svh"
module irq_arbiter (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clkEnable,
   arb_if.arb bus
);
   import irq_pkg::*;

   logic valid;
   vector_t vector;
   level_t level;
   logic next_valid;
   vector_t next_vector;
   level_t next_level;
   logic busy;
   level_t curLevel;
   logic [2:0] maxLvl;

   function automatic level_t srcLevel(input int i, input srcvec_t hi,
      input srcvec_t lo);
      srcLevel = {hi[i], lo[i]}; // see [RULE_04]
   endfunction

   always_comb begin
      busy = |bus.inService;
      curLevel = 2'd0;
      for (int l = 0; l < 4; l++) begin
         if (bus.inService[l]) begin
            curLevel = level_t'(l);
         end
      end
   end

   always_comb begin
      next_valid = 1'b0;
      next_vector = vector;
      next_level = level;
      // descending index so the first in poll order wins ties
      for (int i = `IRQ_NUM_SRC - 1; i >= 0; i--) begin
         if (bus.enable[`IRQ_GATE_BIT] && bus.enable[i] && bus.pending[i]
            && (!next_valid
            || srcLevel(i, bus.prioHi, bus.prioLo) >= next_level)) begin
            // see [RULE_02] [RULE_08] [RULE_09] [RULE_12]
            next_valid = 1'b1;
            next_vector = vector_t'(i);
            next_level = srcLevel(i, bus.prioHi, bus.prioLo);
         end
      end
      if (busy && next_level <= curLevel) begin
         next_valid = 1'b0; // see [RULE_06] [RULE_07]
      end
      if (bus.ack) begin
         next_valid = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         valid <= 1'b0;
         vector <= 3'h0;
         level <= 2'h0;
      end else if (clkEnable) begin
         valid <= next_valid;
         vector <= next_vector;
         level <= next_level;
      end
   end

   assign bus.valid = valid;
   assign bus.vector = vector;
   assign bus.level = level;

   always_comb begin
      maxLvl = 3'd0;
      for (int i = 0; i < `IRQ_NUM_SRC; i++) begin
         if (bus.enable[`IRQ_GATE_BIT] && bus.enable[i] && bus.pending[i]
            && {1'b0, srcLevel(i, bus.prioHi, bus.prioLo)} + 3'd1 > maxLvl) begin
            maxLvl = {1'b0, srcLevel(i, bus.prioHi, bus.prioLo)} + 3'd1;
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   chk_gate_off: assert property ( // see [RULE_02]
      clkEnable && !bus.enable[`IRQ_GATE_BIT] |=> !valid)
      else $error("request presented with the global gate off");
   chk_highest_level: assert property ( // see [RULE_08]
      clkEnable && !bus.ack && !busy && maxLvl != 3'd0
      |=> valid && {1'b0, level} == $past(maxLvl) - 3'd1)
      else $error("winner is not at the highest pending level");
   chk_poll_order: assert property ( // see [RULE_09]
      clkEnable |=> !valid || $past(bus.pending[0] && bus.enable[0]
      && bus.enable[`IRQ_GATE_BIT]) == 1'b0 || vector == 3'd0
      || level > {$past(bus.prioHi[0]), $past(bus.prioLo[0])})
      else $error("a later source beat the first in poll order");
   chk_preempt_strict: assert property ( // see [RULE_06]
      clkEnable && busy |=> !valid || level > $past(curLevel))
      else $error("request presented without strictly higher level");
   chk_top_blocks: assert property ( // see [RULE_07]
      clkEnable && bus.inService[3] |=> !valid)
      else $error("service at top level was interrupted");
endmodule

// >>> rtl/irq_nest_tracker.sv
/*
 * Remembers which priority levels are in service, one bit per level.
 * Assumes the core pulses ack on vector fetch and reti on return.
 */
`timescale 1ns/1ns
module irq_nest_tracker (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clkEnable,
   input wire logic ack,
   input wire irq_pkg::level_t ackLevel,
   input wire logic reti,
   output logic [3:0] inService
);
   import irq_pkg::*;

   logic [3:0] next_inService;

   always_comb begin
      next_inService = inService;
      if (reti) begin
         // return ends the highest level in service
         for (int l = 0; l < 4; l++) begin
            if (inService[l] && (inService >> (l + 1)) == 4'h0) begin
               next_inService[l] = 1'b0;
            end
         end
      end
      if (ack) begin
         next_inService[ackLevel] = 1'b1; // see [RULE_06]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         inService <= 4'h0;
      end else if (clkEnable) begin
         inService <= next_inService;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   chk_push_level: assert property ( // see [RULE_06]
      clkEnable && ack |=> inService[$past(ackLevel)])
      else $error("acknowledged level not marked in service");
endmodule

// >>> rtl/priority_interrupt_controller.sv
/*
 * Seven-source interrupt controller with four levels, nesting, an AXI4-Lite
 * register slave and a sticky event status with mask and interrupt line.
 * Assumes timer, serial and counter array requests are one-cycle pulses on
 * ref_clk; the external pins are asynchronous and active low.
 */
// Local design decision: the AXI4-Lite register port.
// What this block does
// [RULE_01] seven sources, each with its own vector number
// [RULE_02] enable bit 7 gates all requests; else per-source enable bits
// [RULE_03] enable bits: 6 counter array down to 0 ext 0; reset zero
// [RULE_04] level is high bit over low bit; 0 lowest, 3 highest
// [RULE_05] priority registers mirror enable layout; bit 7 reserved; reset zero
// [RULE_06] a service is pre-empted only by a strictly higher level
// [RULE_07] a service at level 3 is never interrupted
// [RULE_08] among pending requests the higher level is granted
// [RULE_09] equal levels are resolved by a fixed polling order
// [RULE_10] enable and low priority allow single-bit access; high only bytes
// [RULE_11] each timer raises its request on counter overflow
// [RULE_12] poll order ext0, tmr0, ext1, tmr1, serial, tmr2, counter array
`timescale 1ns/1ns
`include "irq_defs.svh"
module priority_interrupt_controller (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clkEnable,
   input wire logic extIrq0PinN,
   input wire logic extIrq1PinN,
   input wire logic tmr0Ovf,
   input wire logic tmr1Ovf,
   input wire logic tmr2Ovf,
   input wire logic serialIrq,
   input wire logic counterArrayIrq,
   output logic irqReq,
   output irq_pkg::vector_t irqVector,
   output irq_pkg::level_t irqLevel,
   input wire logic cpuAck,
   input wire logic cpuReti,
   output logic irq,
   input wire irq_pkg::addr_t s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire irq_pkg::addr_t s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import irq_pkg::*;

   function automatic addr_t byteAddr(input logic [11:0] idx);
      byteAddr = {idx, 2'b00};
   endfunction

   function automatic logic isMapped(input addr_t a);
      isMapped = a == byteAddr(`IRQ_IDX_ENABLE)
         || a == byteAddr(`IRQ_IDX_PRIO_HI)
         || a == byteAddr(`IRQ_IDX_PRIO_LO)
         || a == byteAddr(`IRQ_IDX_STATUS)
         || a == byteAddr(`IRQ_IDX_MASK)
         || a == byteAddr(`IRQ_IDX_BITOP)
         || a == byteAddr(`IRQ_IDX_SERVICE);
   endfunction

   arb_if arb ();

   // external pin synchronisers and fall detect
   logic [1:0] pinMeta;
   logic [1:0] pinSync;
   logic [1:0] pinLast;
   srcvec_t srcEvent;

   // register state
   logic [7:0] enable;
   srcvec_t prioLo;
   srcvec_t prioHi;
   srcvec_t pending;
   srcvec_t status;
   srcvec_t mask;
   logic [7:0] next_enable;
   srcvec_t next_prioLo;
   srcvec_t next_prioHi;
   srcvec_t next_pending;
   srcvec_t next_status;
   srcvec_t next_mask;

   // bus state
   logic awHeld;
   addr_t awAddr;
   logic wHeld;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic bValid;
   logic [1:0] bResp;
   logic rValid;
   logic [31:0] rData;
   logic [1:0] rResp;
   logic next_awHeld;
   addr_t next_awAddr;
   logic next_wHeld;
   logic [31:0] next_wData;
   logic [3:0] next_wStrb;
   logic next_bValid;
   logic [1:0] next_bResp;
   logic next_rValid;
   logic [31:0] next_rData;
   logic [1:0] next_rResp;
   logic doWrite;
   logic lane0;
   logic [2:0] bitIdx;
   logic [3:0] inService;
   logic ackTake;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pinMeta <= 2'h3;
         pinSync <= 2'h3;
         pinLast <= 2'h3;
      end else if (clkEnable) begin
         pinMeta <= {extIrq1PinN, extIrq0PinN};
         pinSync <= pinMeta;
         pinLast <= pinSync;
      end
   end

   // bit positions follow the enable layout; see [RULE_01] [RULE_03]
   assign srcEvent = {counterArrayIrq, tmr2Ovf, serialIrq, tmr1Ovf,
      pinLast[1] & ~pinSync[1], tmr0Ovf, pinLast[0] & ~pinSync[0]};
   // timer requests come from overflow pulses only; see [RULE_11]

   assign ackTake = cpuAck && arb.valid;
   assign doWrite = awHeld && wHeld && !bValid;
   assign lane0 = wStrb[0];
   assign bitIdx = wData[`IRQ_BITOP_IDX_LSB +: 3];

   always_comb begin
      next_enable = enable;
      next_prioLo = prioLo;
      next_prioHi = prioHi;
      next_mask = mask;
      next_pending = pending;
      next_status = status;
      if (ackTake) begin
         next_pending[arb.vector] = 1'b0;
      end
      if (doWrite && lane0) begin
         unique case (awAddr)
            byteAddr(`IRQ_IDX_ENABLE): next_enable = wData[7:0];
            byteAddr(`IRQ_IDX_PRIO_LO): next_prioLo = wData[6:0];
            // whole byte only; no bit command reaches it; see [RULE_10]
            byteAddr(`IRQ_IDX_PRIO_HI): next_prioHi = wData[6:0];
            byteAddr(`IRQ_IDX_STATUS): next_status = status & ~wData[6:0];
            byteAddr(`IRQ_IDX_MASK): next_mask = wData[6:0];
            byteAddr(`IRQ_IDX_BITOP): begin
               // see [RULE_10]
               if (!wData[`IRQ_BITOP_SEL_BIT]) begin
                  next_enable[bitIdx] = wData[`IRQ_BITOP_VAL_BIT];
               end else if (bitIdx != 3'd7) begin
                  next_prioLo[bitIdx] = wData[`IRQ_BITOP_VAL_BIT];
               end
            end
            default: begin
            end
         endcase
      end
      // a new event beats a clear in the same cycle
      next_pending = next_pending | srcEvent;
      next_status = next_status | srcEvent;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         enable <= `IRQ_ENABLE_RST; // see [RULE_03]
         prioLo <= `IRQ_PRIO_RST; // see [RULE_05]
         prioHi <= `IRQ_PRIO_RST;
         pending <= 7'h00;
         status <= `IRQ_STATUS_RST;
         mask <= `IRQ_MASK_RST;
      end else if (clkEnable) begin
         enable <= next_enable;
         prioLo <= next_prioLo;
         prioHi <= next_prioHi;
         pending <= next_pending;
         status <= next_status;
         mask <= next_mask;
      end
   end

   always_comb begin
      next_awHeld = awHeld;
      next_awAddr = awAddr;
      next_wHeld = wHeld;
      next_wData = wData;
      next_wStrb = wStrb;
      next_bValid = bValid;
      next_bResp = bResp;
      next_rValid = rValid;
      next_rData = rData;
      next_rResp = rResp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_awHeld = 1'b1;
         next_awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_wHeld = 1'b1;
         next_wData = s_axi_wdata;
         next_wStrb = s_axi_wstrb;
      end
      if (doWrite) begin
         next_awHeld = 1'b0;
         next_wHeld = 1'b0;
         next_bValid = 1'b1;
         next_bResp = isMapped(awAddr)
            && awAddr != byteAddr(`IRQ_IDX_SERVICE)
            ? `IRQ_RESP_OKAY : `IRQ_RESP_SLVERR;
      end else if (bValid && s_axi_bready) begin
         next_bValid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rValid = 1'b1;
         next_rResp = isMapped(s_axi_araddr)
            ? `IRQ_RESP_OKAY : `IRQ_RESP_SLVERR;
         unique case (s_axi_araddr)
            byteAddr(`IRQ_IDX_ENABLE): next_rData = {24'h0, enable};
            // reserved bit 7 reads zero; see [RULE_05]
            byteAddr(`IRQ_IDX_PRIO_LO): next_rData = {25'h0, prioLo};
            byteAddr(`IRQ_IDX_PRIO_HI): next_rData = {25'h0, prioHi};
            byteAddr(`IRQ_IDX_STATUS): next_rData = {25'h0, status};
            byteAddr(`IRQ_IDX_MASK): next_rData = {25'h0, mask};
            byteAddr(`IRQ_IDX_SERVICE): next_rData = {15'h0, pending,
               inService, arb.valid, arb.level, arb.vector};
            default: next_rData = 32'h0;
         endcase
      end else if (rValid && s_axi_rready) begin
         next_rValid = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         awHeld <= 1'b0;
         awAddr <= 14'h0;
         wHeld <= 1'b0;
         wData <= 32'h0;
         wStrb <= 4'h0;
         bValid <= 1'b0;
         bResp <= 2'h0;
         rValid <= 1'b0;
         rData <= 32'h0;
         rResp <= 2'h0;
      end else if (clkEnable) begin
         awHeld <= next_awHeld;
         awAddr <= next_awAddr;
         wHeld <= next_wHeld;
         wData <= next_wData;
         wStrb <= next_wStrb;
         bValid <= next_bValid;
         bResp <= next_bResp;
         rValid <= next_rValid;
         rData <= next_rData;
         rResp <= next_rResp;
      end
   end

   assign s_axi_awready = clkEnable && !awHeld && !bValid;
   assign s_axi_wready = clkEnable && !wHeld && !bValid;
   assign s_axi_bvalid = bValid;
   assign s_axi_bresp = bResp;
   assign s_axi_arready = clkEnable && !rValid;
   assign s_axi_rvalid = rValid;
   assign s_axi_rdata = rData;
   assign s_axi_rresp = rResp;

   assign arb.pending = pending;
   assign arb.enable = enable;
   assign arb.prioLo = prioLo;
   assign arb.prioHi = prioHi;
   assign arb.inService = inService;
   assign arb.ack = ackTake;

   irq_arbiter arbiter (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .clkEnable(clkEnable),
      .bus(arb.arb)
   );

   irq_nest_tracker nest (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .clkEnable(clkEnable),
      .ack(ackTake && clkEnable),
      .ackLevel(arb.level),
      .reti(cpuReti && clkEnable),
      .inService(inService)
   );

   assign irqReq = arb.valid;
   assign irqVector = arb.vector;
   assign irqLevel = arb.level;
   assign irq = |(status & mask);

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   chk_timer_pending: assert property ( // see [RULE_11]
      clkEnable && tmr1Ovf |=> pending[SRC_TMR1] && status[SRC_TMR1])
      else $error("timer 1 overflow did not raise its request");
   chk_status_sticky: assert property (
      clkEnable && status[0] && !(doWrite && lane0
      && awAddr == byteAddr(`IRQ_IDX_STATUS) && wData[0]) |=> status[0])
      else $error("status bit dropped without a clear");
   chk_hi_no_bitop: assert property ( // see [RULE_10]
      clkEnable && doWrite && awAddr == byteAddr(`IRQ_IDX_BITOP)
      |=> prioHi == $past(prioHi))
      else $error("bit command changed the high priority register");
   chk_ack_clears: assert property ( // see [RULE_01]
      clkEnable && ackTake && !srcEvent[arb.vector]
      |=> !pending[$past(arb.vector)] && !irqReq)
      else $error("taken request was not withdrawn");
endmodule

// >>> tb/cpu_core_model.sv
/*
 * Core-side partner: takes the presented vector when allowed, promptly or
 * after a few cycles, and issues a return pulse on command.
 * Assumes the controller and this model share ref_clk and sys_rst.
 */
`timescale 1ns/1ns
module cpu_core_model (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic irqReq,
   input wire irq_pkg::vector_t irqVector,
   input wire logic ackOn,
   input wire logic ackSlow,
   input wire logic retiGo,
   output logic cpuAck,
   output logic cpuReti,
   output irq_pkg::vector_t lastVec
);
   import irq_pkg::*;
   logic [2:0] waitCnt;
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cpuAck <= 1'h0;
         cpuReti <= 1'h0;
         lastVec <= 3'h0;
         waitCnt <= 3'h0;
      end else begin
         cpuReti <= retiGo;
         cpuAck <= 1'h0;
         // one pulse per presentation; irqReq lingers a cycle after it
         if (!irqReq || !ackOn || cpuAck) begin
            waitCnt <= 3'h0;
         end else if (waitCnt >= (ackSlow ? 3'h4 : 3'h0)) begin
            cpuAck <= 1'h1;
            lastVec <= irqVector;
            waitCnt <= 3'h0;
         end else begin
            waitCnt <= waitCnt + 3'h1;
         end
      end
   end
endmodule

// >>> tb/priority_interrupt_controller_tb_top.sv
/*
 * Self-checking bench: register access over AXI4-Lite, a table of
 * arbitration cases, then nesting and event status by hand.
 * Assumes the controller, its package and cpu_core_model are compiled.
 */
`timescale 1ns/1ns
`include "irq_defs.svh"
module priority_interrupt_controller_tb_top;
   import irq_pkg::*;
   typedef struct packed {
      logic [7:0] en;
      logic [7:0] hi;
      logic [7:0] lo;
      srcvec_t src;
      logic req;
      vector_t vec;
      level_t lvl;
   } row_s;
   localparam logic [1:0] OK = `IRQ_RESP_OKAY;
   localparam logic [1:0] ERR = `IRQ_RESP_SLVERR;
   row_s rows [8] = '{
      '{8'hff, 8'h00, 8'h00, 7'h7f, 1'h1, 3'h0, 2'h0},
      '{8'hfe, 8'h00, 8'h00, 7'h7f, 1'h1, 3'h1, 2'h0},
      '{8'hff, 8'h40, 8'h40, 7'h7f, 1'h1, 3'h6, 2'h3},
      '{8'hff, 8'h00, 8'h20, 7'h7f, 1'h1, 3'h5, 2'h1},
      '{8'h7f, 8'h00, 8'h00, 7'h7f, 1'h0, 3'h0, 2'h0},
      '{8'hff, 8'h10, 8'h08, 7'h7f, 1'h1, 3'h4, 2'h2},
      '{8'hff, 8'h00, 8'h00, 7'h0c, 1'h1, 3'h2, 2'h0},
      '{8'hc0, 8'h00, 8'h00, 7'h3f, 1'h0, 3'h0, 2'h0}};
   logic ref_clk = 1'h0, sys_rst = 1'h1, clkEnable = 1'h1;
   logic extIrq0PinN = 1'h1, extIrq1PinN = 1'h1, tmr0Ovf = 1'h0;
   logic tmr1Ovf = 1'h0, tmr2Ovf = 1'h0, serialIrq = 1'h0;
   logic counterArrayIrq = 1'h0, ackOn = 1'h0, ackSlow = 1'h0;
   logic retiGo = 1'h0, irqReq, cpuAck, cpuReti, irq;
   vector_t irqVector, lastVec;
   level_t irqLevel;
   addr_t s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int n_mismatch = 0, check_count = 0, cycles = 0;

   priority_interrupt_controller dut (.ref_clk, .sys_rst, .clkEnable,
      .extIrq0PinN, .extIrq1PinN, .tmr0Ovf, .tmr1Ovf, .tmr2Ovf, .serialIrq,
      .counterArrayIrq, .irqReq, .irqVector, .irqLevel, .cpuAck, .cpuReti,
      .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   cpu_core_model core (.ref_clk, .sys_rst, .irqReq, .irqVector, .ackOn,
      .ackSlow, .retiGo, .cpuAck, .cpuReti, .lastVec);

   always #5 ref_clk = ~ref_clk;

   task finish_test;
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // hang guard, well above the expected run length
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         finish_test;
      end
   end

   task check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   function automatic addr_t ba(input logic [11:0] idx);
      return {idx, 2'b00};
   endfunction

   task rst(input int n);
      sys_rst <= 1'h1;
      repeat (n) @(posedge ref_clk);
      sys_rst <= 1'h0;
   endtask

   // ready is settled at the falling edge, so decide there, act after rise
   task wrchk(input addr_t a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] er);
      logic aw, w, b;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      aw = 1'h0;
      w = 1'h0;
      b = 1'h0;
      while (!(aw && w)) begin
         @(negedge ref_clk);
         aw = aw | s_axi_awready;
         w = w | s_axi_wready;
         @(posedge ref_clk);
         if (aw) s_axi_awvalid <= 1'h0;
         if (w) s_axi_wvalid <= 1'h0;
      end
      while (!b) begin
         @(negedge ref_clk);
         b = s_axi_bvalid;
         if (b) check(s_axi_bresp, er);
         @(posedge ref_clk);
      end
      s_axi_bready <= 1'h0;
      @(posedge ref_clk);
   endtask

   task rdchk(input addr_t a, input logic [31:0] ed, input logic [1:0] er);
      logic t;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      t = 1'h0;
      while (!t) begin
         @(negedge ref_clk);
         t = s_axi_arready;
         @(posedge ref_clk);
      end
      s_axi_arvalid <= 1'h0;
      t = 1'h0;
      while (!t) begin
         @(negedge ref_clk);
         t = s_axi_rvalid;
         if (t) check(s_axi_rdata, ed);
         if (t) check(s_axi_rresp, er);
         @(posedge ref_clk);
      end
      s_axi_rready <= 1'h0;
      @(posedge ref_clk);
   endtask

   // external pins fall first so all requests are pending together
   task fire(input srcvec_t s);
      extIrq0PinN <= !s[0];
      extIrq1PinN <= !s[2];
      repeat (4) @(posedge ref_clk);
      {counterArrayIrq, tmr2Ovf, serialIrq, tmr1Ovf, tmr0Ovf} <=
         {s[6], s[5], s[4], s[3], s[1]};
      @(posedge ref_clk);
      {counterArrayIrq, tmr2Ovf, serialIrq, tmr1Ovf, tmr0Ovf} <= 5'h00;
      extIrq0PinN <= 1'h1;
      extIrq1PinN <= 1'h1;
      repeat (6) @(posedge ref_clk);
   endtask

   task expq(input logic r, input vector_t v, input level_t l);
      @(negedge ref_clk);
      check(irqReq, r);
      if (r) check(irqVector, v);
      if (r) check(irqLevel, l);
      @(posedge ref_clk);
   endtask

   task take(input vector_t v);
      logic a;
      ackOn <= 1'h1;
      a = 1'h0;
      for (int k = 0; k < 30 && !a; k++) begin
         @(negedge ref_clk);
         a = cpuAck;
         @(posedge ref_clk);
      end
      ackOn <= 1'h0;
      check(a, 1'h1);
      check(lastVec, v);
   endtask

   task irqchk(input logic e);
      @(negedge ref_clk);
      check(irq, e);
      @(posedge ref_clk);
   endtask

   initial begin
      rst(20);
      foreach (rows[i]) begin
         if (i != 0) rst(2);
         wrchk(ba(`IRQ_IDX_ENABLE), {24'h0, rows[i].en}, 4'h1, OK);
         wrchk(ba(`IRQ_IDX_PRIO_HI), {24'h0, rows[i].hi}, 4'h1, OK);
         wrchk(ba(`IRQ_IDX_PRIO_LO), {24'h0, rows[i].lo}, 4'h1, OK);
         fire(rows[i].src);
         expq(rows[i].req, rows[i].vec, rows[i].lvl);
      end
      // nesting: tmr0/tmr1 level 1, serial 2, tmr2 and counter array 3
      rst(2);
      wrchk(ba(`IRQ_IDX_ENABLE), 32'hff, 4'h1, OK);
      wrchk(ba(`IRQ_IDX_PRIO_HI), 32'h70, 4'h1, OK);
      wrchk(ba(`IRQ_IDX_PRIO_LO), 32'h6a, 4'h1, OK);
      ackSlow <= 1'h1;
      fire(7'h02);
      expq(1'h1, 3'h1, 2'h1);
      take(3'h1);
      ackSlow <= 1'h0;
      fire(7'h08);
      expq(1'h0, 3'h0, 2'h0);
      fire(7'h10);
      expq(1'h1, 3'h4, 2'h2);
      take(3'h4);
      fire(7'h40);
      expq(1'h1, 3'h6, 2'h3);
      take(3'h6);
      fire(7'h20);
      expq(1'h0, 3'h0, 2'h0);
      retiGo <= 1'h1;
      @(posedge ref_clk);
      retiGo <= 1'h0;
      repeat (6) @(posedge ref_clk);
      expq(1'h1, 3'h5, 2'h3);
      // pending tmr1, tmr2; levels 1, 2 in service; tmr2 shown at 3
      rdchk(ba(`IRQ_IDX_SERVICE), 32'ha1bd, OK);
      // sticky status, mask and the interrupt line
      irqchk(1'h0);
      wrchk(ba(`IRQ_IDX_MASK), 32'h20, 4'h1, OK);
      irqchk(1'h1);
      wrchk(ba(`IRQ_IDX_STATUS), 32'h20, 4'h1, OK);
      irqchk(1'h0);
      rdchk(ba(`IRQ_IDX_STATUS), 32'h5a, OK);
      // mid-run reset clears registers, status and the request
      rst(2);
      expq(1'h0, 3'h0, 2'h0);
      rdchk(ba(`IRQ_IDX_STATUS), 32'h0, OK);
      rdchk(ba(`IRQ_IDX_ENABLE), 32'h0, OK);
      rdchk(ba(`IRQ_IDX_PRIO_HI), 32'h0, OK);
      rdchk(ba(`IRQ_IDX_PRIO_LO), 32'h0, OK);
      wrchk(ba(`IRQ_IDX_PRIO_HI), 32'hff, 4'h1, OK);
      rdchk(ba(`IRQ_IDX_PRIO_HI), 32'h7f, OK);
      wrchk(ba(`IRQ_IDX_PRIO_HI), 32'h0, 4'h0, OK);
      rdchk(ba(`IRQ_IDX_PRIO_HI), 32'h7f, OK);
      wrchk(ba(`IRQ_IDX_BITOP), 32'h1a, 4'h1, OK);
      rdchk(ba(`IRQ_IDX_PRIO_LO), 32'h04, OK);
      wrchk(ba(`IRQ_IDX_BITOP), 32'h0f, 4'h1, OK);
      rdchk(ba(`IRQ_IDX_ENABLE), 32'h80, OK);
      rdchk(14'h0000, 32'h0, ERR);
      wrchk(ba(`IRQ_IDX_SERVICE), 32'h1, 4'h1, ERR);
      finish_test;
   end
endmodule
